// ===== jesd_rx_map.svh
// register offsets, field positions, reset values and timing defaults of the receive link block
`ifndef JESD_RX_MAP_SVH
`define JESD_RX_MAP_SVH

// ==========================================================================
// register offsets
`define OFS_PAIR_SEL 12'h008
`define OFS_IRQ_EN_A 12'h021
`define OFS_IRQ_EN_B 12'h022
`define OFS_IRQ_ST_A 12'h025
`define OFS_IRQ_ST_B 12'h026
`define OFS_ERR_WIN 12'h034
`define OFS_SNAP_ERR 12'h038
`define OFS_SNAP_FLAG 12'h039
`define OFS_SYNC_CTL 12'h03a
`define OFS_SYNC_STAT 12'h03b
`define OFS_CUR_ERR 12'h03c
`define OFS_SIDE_FLAG 12'h03d
`define OFS_LINK_CTL 12'h300
`define OFS_SUBCLASS 12'h301
`define OFS_SCR_CFG 12'h453

// ==========================================================================
// field positions
`define BIT_TWO_LINK 3
`define BIT_LINK_SEL 2
`define BIT_SCR_EN 7
`define BIT_SYNC_EN 7
`define BIT_SYNC_ARM 6
`define BIT_CLR_STKY 5
`define BIT_ST_BUSY 7
`define BIT_ST_LOCK 3
`define BIT_ST_ROTA 2
`define BIT_ST_WLIM 1
`define BIT_ST_TRIP 0

// ==========================================================================
// mode codes, reset values and timing defaults
`define MODE_ONESHOT 4'h1
`define MODE_CONT 4'h2
`define MODE_MONITOR 4'h9
`define RST_BYTE 8'h00
`define LMFC_PERIOD_DEF 8'h20
`define ROT_CYCLES_DEF 8'h04

`endif

// ===== jesd_rx_pkg.sv
// types shared by the receive link block
`default_nettype none
package jesd_rx_pkg;

   // ==========================================================================
   // one deframed word of a link: four octets and their control-character flags
   typedef struct packed {
      logic valid;
      logic [3:0] ctrl;
      logic [31:0] data;
   } frame_type;

   // per-pair multiframe clock alignment state
   typedef enum logic {ST_WAIT, ST_ROTATE} sync_state_type;

endpackage
`default_nettype wire

// ===== jesd_rx_deframer_lmfc_sync.sv
// two four-octet deframers with descramblers and the multiframe clock sync machine
`timescale 1ns/1ps
`default_nettype none
`include "jesd_rx_map.svh"

// Summary of operation
// - two deframers decode 8b/10b and descramble four octets per processing clock
// - single link runs deframer 0 only; dual link runs both
// - link control bit 3 selects dual link (1) or single link (0)
// - link control bit 2 picks which deframer later config accesses reach
// - descrambler is self-synchronous, polynomial 1 + x^14 + x^15
// - descrambling happens only while scrambling config bit 7 is set
// - each pair has its own multiframe clock, aligned to internal or SYSREF edge
// - SYSREF is active high, sampled on rising clock; pulse, step or periodic
// - one-shot, continuous and armed monitor edges phase-check and rotate the multiframe clock when beyond tolerance
// - one-shot checks only first edge after arming, adjusts only beyond window
// - continuous checks every edge, no arm needed, first edge already checked
// - edges arriving during a rotation are ignored until rotation is done
// - nonzero window still checks every edge, rotates only beyond tolerance
// - arm bit self-clears on an edge; in continuous mode it changes nothing
// - monitor mode aligns on first armed edge, then only measures and reports
// - current error reads zero after alignment, else measured error in clocks
// - error beyond tolerance sets low-side or high-side flag bit
// - each alignment copies last error and flags into snapshot registers
// - status shows busy bit 7, lock bit 3, window-limit bit 1, refreshed each check
// - rotation and edge-seen flags are sticky, cleared by clear-sticky bit 5
// - window 0 means half a clock, 1 to 7 mean that many clocks
// - sync statuses per pair are enabled interrupt events, cleared on read back
module jesd_rx_deframer_lmfc_sync import jesd_rx_pkg::*; #(
   parameter logic [7:0] LMFC_PERIOD = `LMFC_PERIOD_DEF,
   parameter logic [7:0] ROT_CYCLES = `ROT_CYCLES_DEF
) (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic SYSREF_I,
   input wire logic [1:0][39:0] LANE_SYM_I,
   input wire logic [1:0] LANE_VALID_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [11:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   output var logic [7:0] REG_RDATA_O,
   output var logic IRQ_O,
   output var logic [1:0] LMFC_PULSE_O,
   output var frame_type [1:0] FRAME_O
);

   // ==========================================================================
   // 8b/10b decode helpers; symbol is {a,b,c,d,e,i,f,g,h,j}, first bit on the left
   function automatic logic [4:0] dec6(input logic [5:0] c);
      case (c)
         6'b100111, 6'b011000: dec6 = 5'd0;
         6'b011101, 6'b100010: dec6 = 5'd1;
         6'b101101, 6'b010010: dec6 = 5'd2;
         6'b110001: dec6 = 5'd3;
         6'b110101, 6'b001010: dec6 = 5'd4;
         6'b101001: dec6 = 5'd5;
         6'b011001: dec6 = 5'd6;
         6'b111000, 6'b000111: dec6 = 5'd7;
         6'b111001, 6'b000110: dec6 = 5'd8;
         6'b100101: dec6 = 5'd9;
         6'b010101: dec6 = 5'd10;
         6'b110100: dec6 = 5'd11;
         6'b001101: dec6 = 5'd12;
         6'b101100: dec6 = 5'd13;
         6'b011100: dec6 = 5'd14;
         6'b010111, 6'b101000: dec6 = 5'd15;
         6'b011011, 6'b100100: dec6 = 5'd16;
         6'b100011: dec6 = 5'd17;
         6'b010011: dec6 = 5'd18;
         6'b110010: dec6 = 5'd19;
         6'b001011: dec6 = 5'd20;
         6'b101010: dec6 = 5'd21;
         6'b011010: dec6 = 5'd22;
         6'b111010, 6'b000101: dec6 = 5'd23;
         6'b110011, 6'b001100: dec6 = 5'd24;
         6'b100110: dec6 = 5'd25;
         6'b010110: dec6 = 5'd26;
         6'b110110, 6'b001001: dec6 = 5'd27;
         6'b001110, 6'b001111, 6'b110000: dec6 = 5'd28;
         6'b101110, 6'b010001: dec6 = 5'd29;
         6'b011110, 6'b100001: dec6 = 5'd30;
         6'b101011, 6'b010100: dec6 = 5'd31;
         default: dec6 = 5'd0;
      endcase
   endfunction

   function automatic logic [2:0] dec4(input logic [3:0] c);
      case (c)
         4'b1011, 4'b0100: dec4 = 3'd0;
         4'b1001: dec4 = 3'd1;
         4'b0101: dec4 = 3'd2;
         4'b1100, 4'b0011: dec4 = 3'd3;
         4'b1101, 4'b0010: dec4 = 3'd4;
         4'b1010: dec4 = 3'd5;
         4'b0110: dec4 = 3'd6;
         default: dec4 = 3'd7;
      endcase
   endfunction

   // bit-serial view of the 1 + x^14 + x^15 self-synchronous descrambler, msb first
   function automatic logic [46:0] descr(input logic [31:0] din, input logic [14:0] st);
      logic [14:0] s;
      logic [31:0] o;
      s = st;
      o = 32'h0;
      for (int i = 31; i >= 0; i--) begin
         o[i] = din[i] ^ s[13] ^ s[14];
         s = {s[13:0], din[i]};
      end
      descr = {s, o};
   endfunction

   // ==========================================================================
   // configuration and sync state
   logic [1:0] pair_sel, next_pair_sel;
   logic [2:0] err_win, next_err_win;
   logic two_link, next_two_link;
   logic link_sel, next_link_sel;
   logic [2:0] subclass, next_subclass;
   logic [1:0] scr_en, next_scr_en;
   logic [3:0] sync_mode, next_sync_mode;
   logic sync_en, next_sync_en;
   logic arm, next_arm;
   logic [1:0][3:0] irq_en, next_irq_en;
   logic [1:0][3:0] irq_st, next_irq_st;
   logic [1:0][7:0] lmfc, next_lmfc;
   logic [7:0] ref_cnt, next_ref_cnt;
   logic [1:0][7:0] rot_cnt, next_rot_cnt;
   sync_state_type state [2];
   sync_state_type next_state [2];
   logic [1:0][7:0] cur_err, next_cur_err;
   logic [1:0][1:0] side, next_side;
   logic [1:0][7:0] snap_err, next_snap_err;
   logic [1:0][1:0] snap_side, next_snap_side;
   logic [1:0] lock, next_lock;
   logic [1:0] wlim, next_wlim;
   logic [1:0] rota, next_rota;
   logic [1:0] trip, next_trip;
   logic [1:0] lmfc_pulse, next_lmfc_pulse;
   logic irq, next_irq;
   logic [7:0] rdata, next_rdata;

   // sysref synchroniser; only the second stage and the edge stage are read by logic
   logic sref_meta, sref_sync, sref_last;
   logic align_edge;

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         sref_meta <= 1'b0;
         sref_sync <= 1'b0;
         sref_last <= 1'b0;
      end else begin
         sref_meta <= SYSREF_I;
         sref_sync <= sref_meta;
         sref_last <= sref_sync;
      end
   end

   // a held-high step gives one edge only; subclass 0 uses the internal reference wrap
   always_comb begin
      if (subclass == 3'h0) begin
         align_edge = (ref_cnt == 8'h00);
      end else begin
         align_edge = sref_sync & ~sref_last;
      end
   end

   // register writes, sync machine per pair, sticky flags, interrupt events, read data
   always_comb begin
      logic [7:0] err;
      logic hi_side, exceed, align_try, mon_only, edge_any, clr_sticky, arm_set;
      logic [3:0] ev;
      logic [1:0] flags;
      logic v;
      err = 8'h00;
      hi_side = 1'b0;
      exceed = 1'b0;
      align_try = 1'b0;
      mon_only = 1'b0;
      edge_any = 1'b0;
      clr_sticky = 1'b0;
      arm_set = 1'b0;
      ev = 4'h0;
      flags = 2'b00;
      next_pair_sel = pair_sel;
      next_err_win = err_win;
      next_two_link = two_link;
      next_link_sel = link_sel;
      next_subclass = subclass;
      next_scr_en = scr_en;
      next_sync_mode = sync_mode;
      next_sync_en = sync_en;
      next_irq_en = irq_en;
      next_irq_st = irq_st;
      next_lmfc = lmfc;
      next_rot_cnt = rot_cnt;
      next_cur_err = cur_err;
      next_side = side;
      next_snap_err = snap_err;
      next_snap_side = snap_side;
      next_lock = lock;
      next_wlim = wlim;
      next_rota = rota;
      next_trip = trip;
      next_state = state;
      next_ref_cnt = (ref_cnt == LMFC_PERIOD - 8'h01) ? 8'h00 : ref_cnt + 8'h01;
      // write decode; the clear-sticky bit acts on write and never reads back
      if (REG_WR_I) begin
         if (REG_ADDR_I == `OFS_PAIR_SEL) begin
            next_pair_sel = REG_WDATA_I[1:0];
         end else if (REG_ADDR_I == `OFS_IRQ_EN_A) begin
            next_irq_en[0] = REG_WDATA_I[3:0];
         end else if (REG_ADDR_I == `OFS_IRQ_EN_B) begin
            next_irq_en[1] = REG_WDATA_I[3:0];
         end else if (REG_ADDR_I == `OFS_ERR_WIN) begin
            next_err_win = REG_WDATA_I[2:0];
         end else if (REG_ADDR_I == `OFS_SYNC_CTL) begin
            next_sync_mode = REG_WDATA_I[3:0];
            next_sync_en = REG_WDATA_I[`BIT_SYNC_EN];
            arm_set = REG_WDATA_I[`BIT_SYNC_ARM];
            clr_sticky = REG_WDATA_I[`BIT_CLR_STKY];
         end else if (REG_ADDR_I == `OFS_LINK_CTL) begin
            next_two_link = REG_WDATA_I[`BIT_TWO_LINK];
            next_link_sel = REG_WDATA_I[`BIT_LINK_SEL];
         end else if (REG_ADDR_I == `OFS_SUBCLASS) begin
            next_subclass = REG_WDATA_I[2:0];
         end else if (REG_ADDR_I == `OFS_SCR_CFG) begin
            next_scr_en[link_sel] = REG_WDATA_I[`BIT_SCR_EN];
         end
      end
      // sticky flags drop first so that a same-cycle event below wins
      if (clr_sticky) begin
         next_rota = 2'b00;
         next_trip = 2'b00;
      end
      for (int p = 0; p < 2; p++) begin
         ev = 4'h0;
         next_lmfc[p] = (lmfc[p] == LMFC_PERIOD - 8'h01) ? 8'h00 : lmfc[p] + 8'h01;
         case (state[p])
            ST_ROTATE: begin
               next_rot_cnt[p] = rot_cnt[p] - 8'h01;
               if (rot_cnt[p] == 8'h00) begin
                  next_state[p] = ST_WAIT;
               end
            end
            default: begin
               // edges during a rotation never reach this branch
               if (align_edge && sync_en && pair_sel[p]) begin
                  edge_any = 1'b1;
                  // phase error is the counter distance from its wrap at the edge
                  if (lmfc[p] <= (LMFC_PERIOD >> 1)) begin
                     err = lmfc[p];
                     hi_side = 1'b1;
                  end else begin
                     err = LMFC_PERIOD - lmfc[p];
                     hi_side = 1'b0;
                  end
                  // window 0 is half a clock, so any whole-clock error exceeds it
                  exceed = (err_win == 3'h0) ? (err != 8'h00) : (err > {5'h00, err_win});
                  flags = exceed ? (hi_side ? 2'b10 : 2'b01) : 2'b00;
                  align_try = (sync_mode == `MODE_CONT) ||
                     (arm && ((sync_mode == `MODE_ONESHOT) || (sync_mode == `MODE_MONITOR)));
                  mon_only = (sync_mode == `MODE_MONITOR) && !arm;
                  if (align_try || mon_only) begin
                     next_trip[p] = 1'b1;
                     next_lock[p] = !exceed;
                     next_wlim[p] = exceed;
                     ev[2] = 1'b1;
                     ev[0] = !exceed;
                     ev[3] = exceed;
                     next_cur_err[p] = err;
                     next_side[p] = flags;
                  end
                  if (align_try) begin
                     next_snap_err[p] = cur_err[p];
                     next_snap_side[p] = side[p];
                     if (exceed) begin
                        // edge cycle becomes phase zero, so the next cycle is one
                        next_lmfc[p] = 8'h01;
                        next_rot_cnt[p] = ROT_CYCLES - 8'h01;
                        next_state[p] = ST_ROTATE;
                        next_rota[p] = 1'b1;
                        next_lock[p] = 1'b1;
                        ev[1] = 1'b1;
                        ev[0] = 1'b1;
                     end
                     next_cur_err[p] = 8'h00;
                  end
               end
            end
         endcase
         // read back of the status clears it; a new event in the same cycle still lands
         if (REG_RD_I && (REG_ADDR_I == ((p == 0) ? `OFS_IRQ_ST_A : `OFS_IRQ_ST_B))) begin
            next_irq_st[p] = 4'h0;
         end
         next_irq_st[p] = next_irq_st[p] | (ev & irq_en[p]);
         next_lmfc_pulse[p] = (next_lmfc[p] == 8'h00);
      end
      // arm self-clears on a taken edge; a fresh arm write in that cycle wins
      next_arm = arm_set | (arm & ~edge_any);
      next_irq = |(next_irq_st[0] & irq_en[0]) | |(next_irq_st[1] & irq_en[1]);
      // status registers show pair a when it is selected, otherwise pair b
      v = pair_sel[0] ? 1'b0 : 1'b1;
      next_rdata = rdata;
      if (REG_RD_I) begin
         if (REG_ADDR_I == `OFS_PAIR_SEL) begin
            next_rdata = {6'h00, pair_sel};
         end else if (REG_ADDR_I == `OFS_IRQ_EN_A) begin
            next_rdata = {4'h0, irq_en[0]};
         end else if (REG_ADDR_I == `OFS_IRQ_EN_B) begin
            next_rdata = {4'h0, irq_en[1]};
         end else if (REG_ADDR_I == `OFS_IRQ_ST_A) begin
            next_rdata = {4'h0, irq_st[0]};
         end else if (REG_ADDR_I == `OFS_IRQ_ST_B) begin
            next_rdata = {4'h0, irq_st[1]};
         end else if (REG_ADDR_I == `OFS_ERR_WIN) begin
            next_rdata = {5'h00, err_win};
         end else if (REG_ADDR_I == `OFS_SNAP_ERR) begin
            next_rdata = snap_err[v];
         end else if (REG_ADDR_I == `OFS_SNAP_FLAG) begin
            next_rdata = {snap_side[v], 6'h00};
         end else if (REG_ADDR_I == `OFS_SYNC_CTL) begin
            next_rdata = {sync_en, arm, 2'b00, sync_mode};
         end else if (REG_ADDR_I == `OFS_SYNC_STAT) begin
            next_rdata = {(state[v] == ST_ROTATE), 3'h0, lock[v], rota[v], wlim[v], trip[v]};
         end else if (REG_ADDR_I == `OFS_CUR_ERR) begin
            next_rdata = cur_err[v];
         end else if (REG_ADDR_I == `OFS_SIDE_FLAG) begin
            next_rdata = {side[v], 6'h00};
         end else if (REG_ADDR_I == `OFS_LINK_CTL) begin
            next_rdata = {4'h0, two_link, link_sel, 2'b00};
         end else if (REG_ADDR_I == `OFS_SUBCLASS) begin
            next_rdata = {5'h00, subclass};
         end else if (REG_ADDR_I == `OFS_SCR_CFG) begin
            next_rdata = {scr_en[link_sel], 7'h00};
         end else begin
            next_rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         pair_sel <= 2'h0;
         err_win <= 3'h0;
         two_link <= 1'b0;
         link_sel <= 1'b0;
         subclass <= 3'h0;
         scr_en <= 2'h0;
         sync_mode <= 4'h0;
         sync_en <= 1'b0;
         arm <= 1'b0;
         irq_en <= '0;
         irq_st <= '0;
         lmfc <= '0;
         ref_cnt <= 8'h00;
         rot_cnt <= '0;
         state[0] <= ST_WAIT;
         state[1] <= ST_WAIT;
         cur_err <= '0;
         side <= '0;
         snap_err <= '0;
         snap_side <= '0;
         lock <= 2'h0;
         wlim <= 2'h0;
         rota <= 2'h0;
         trip <= 2'h0;
         lmfc_pulse <= 2'h0;
         irq <= 1'b0;
         rdata <= `RST_BYTE;
      end else begin
         pair_sel <= next_pair_sel;
         err_win <= next_err_win;
         two_link <= next_two_link;
         link_sel <= next_link_sel;
         subclass <= next_subclass;
         scr_en <= next_scr_en;
         sync_mode <= next_sync_mode;
         sync_en <= next_sync_en;
         arm <= next_arm;
         irq_en <= next_irq_en;
         irq_st <= next_irq_st;
         lmfc <= next_lmfc;
         ref_cnt <= next_ref_cnt;
         rot_cnt <= next_rot_cnt;
         state <= next_state;
         cur_err <= next_cur_err;
         side <= next_side;
         snap_err <= next_snap_err;
         snap_side <= next_snap_side;
         lock <= next_lock;
         wlim <= next_wlim;
         rota <= next_rota;
         trip <= next_trip;
         lmfc_pulse <= next_lmfc_pulse;
         irq <= next_irq;
         rdata <= next_rdata;
      end
   end

   // ==========================================================================
   // deframers: decode four symbols per cycle, descramble data when enabled
   logic [1:0][14:0] scr_st, next_scr_st;
   frame_type [1:0] frame, next_frame;

   always_comb begin
      logic [31:0] raw;
      logic [3:0] ctl;
      logic [46:0] dres;
      logic [9:0] sym;
      raw = 32'h0;
      ctl = 4'h0;
      dres = 47'h0;
      sym = 10'h0;
      next_scr_st = scr_st;
      next_frame = frame;
      for (int l = 0; l < 2; l++) begin
         for (int o = 0; o < 4; o++) begin
            sym = LANE_SYM_I[l][o * 10 +: 10];
            // a positive-disparity K28 inverts its 4b group, so undo that before lookup
            raw[o * 8 +: 8] = {dec4((sym[9:4] == 6'b110000) ? ~sym[3:0] : sym[3:0]),
               dec6(sym[9:4])};
            ctl[o] = (sym[9:4] == 6'b001111) || (sym[9:4] == 6'b110000);
         end
         dres = descr(raw, scr_st[l]);
         next_frame[l].valid = 1'b0;
         // second deframer stays idle in single-link operation
         if (LANE_VALID_I[l] && ((l == 0) || two_link)) begin
            next_frame[l].valid = 1'b1;
            next_frame[l].ctrl = ctl;
            next_frame[l].data = scr_en[l] ? dres[31:0] : raw;
            next_scr_st[l] = dres[46:32];
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         scr_st <= '0;
         frame <= '0;
      end else begin
         scr_st <= next_scr_st;
         frame <= next_frame;
      end
   end

   // every output straight from a flip-flop
   assign REG_RDATA_O = rdata;
   assign IRQ_O = irq;
   assign LMFC_PULSE_O = lmfc_pulse;
   assign FRAME_O = frame;

endmodule

`default_nettype wire

// ===== jesd_rx_checker.sv
// port assertions for the receive link block
`timescale 1ns/1ps
`default_nettype none
module jesd_rx_checker import jesd_rx_pkg::*; (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic [1:0][39:0] LANE_SYM_I,
   input wire logic [1:0] LANE_VALID_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [11:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic [7:0] REG_RDATA_O,
   input wire logic [1:0] LMFC_PULSE_O,
   input wire frame_type [1:0] FRAME_O
);
   // ==========================================================================
   // mirror of the link count bit, so link 1 silence can be judged
   logic dual;
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) dual <= 1'b0;
      else if (REG_WR_I && REG_ADDR_I == 12'h300) dual <= REG_WDATA_I[3];
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   // ==========================================================================
   // deframer and register port relations
   a_frame_valid_set: assert property (LANE_VALID_I[0] |=> FRAME_O[0].valid)
      else $error("frame valid missing");
   a_frame_valid_clear: assert property (!LANE_VALID_I[0] |=> !FRAME_O[0].valid)
      else $error("frame valid without input");
   a_single_link_idle: assert property (!dual |=> !FRAME_O[1].valid)
      else $error("second link active in single link");
   a_ctrl_flag_kept: assert property (LANE_VALID_I[0] && LANE_SYM_I[0][9:0] == 10'h0fa
      |=> FRAME_O[0].ctrl[0])
      else $error("comma not flagged");
   a_rdata_holds: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
      else $error("read data moved without read");
   a_unmapped_zero: assert property (REG_RD_I && REG_ADDR_I == 12'h100 |=> REG_RDATA_O == 8'h00)
      else $error("unmapped read not zero");
   a_clear_reads_zero: assert property (REG_RD_I && REG_ADDR_I == 12'h03a
      |=> !REG_RDATA_O[5])
      else $error("clear bit reads back set");
   a_lmfc_one_cycle: assert property (LMFC_PULSE_O[0] |=> !LMFC_PULSE_O[0])
      else $error("multiframe pulse too long");
endmodule
bind jesd_rx_deframer_lmfc_sync jesd_rx_checker i_jesd_rx_checker (.CLK_I(CLK_I),
   .SYS_RST_I(SYS_RST_I), .LANE_SYM_I(LANE_SYM_I), .LANE_VALID_I(LANE_VALID_I),
   .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I),
   .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .LMFC_PULSE_O(LMFC_PULSE_O),
   .FRAME_O(FRAME_O));
`default_nettype wire

// ===== jesd_rx_lane_src.sv
// behavioural link transmitter sending comma words on both links
`timescale 1ns/1ps
`default_nettype none
module jesd_rx_lane_src (
   input wire logic clk_i,
   input wire logic [1:0] en_i,
   output var logic [1:0][39:0] sym_o,
   output var logic [1:0] valid_o
);
   // alternating disparity commas keep the decoder free of disparity faults
   localparam logic [39:0] COMMA = {10'h305, 10'h0fa, 10'h305, 10'h0fa};
   logic [1:0] en_q;
   initial begin
      sym_o = '0;
      valid_o = '0;
   end
   // idle lanes toggle so stale symbols never pass for data
   always @(posedge clk_i) begin
      en_q = en_i;
      #1;
      for (int l = 0; l < 2; l++) begin
         valid_o[l] <= en_q[l];
         sym_o[l] <= en_q[l] ? COMMA : ~sym_o[l];
      end
   end
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking testbench of the receive link block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import jesd_rx_pkg::*;
   logic clk = 0, rst = 1, sysref = 0, wr_s = 0, rd_s = 0, irq;
   logic [11:0] addr = '0;
   logic [7:0] wdata = '0, rdata;
   logic [1:0] lane_en = '0, lmfc, lvalid;
   logic [1:0][39:0] lsym;
   frame_type [1:0] frame;
   frame_type comma = {1'b1, 4'hf, 32'hbcbcbcbc};
   int miscompares = 0, num_checks = 0;
   jesd_rx_deframer_lmfc_sync #(.LMFC_PERIOD(8'h08), .ROT_CYCLES(8'h02))
      i_jesd_rx_deframer_lmfc_sync (.CLK_I(clk), .SYS_RST_I(rst), .SYSREF_I(sysref),
      .LANE_SYM_I(lsym), .LANE_VALID_I(lvalid), .REG_WR_I(wr_s), .REG_RD_I(rd_s),
      .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .IRQ_O(irq),
      .LMFC_PULSE_O(lmfc), .FRAME_O(frame));
   jesd_rx_lane_src i_jesd_rx_lane_src (.clk_i(clk), .en_i(lane_en), .sym_o(lsym),
      .valid_o(lvalid));
   initial begin
      forever #25 clk = ~clk;
   end
   // ==========================================================================
   // compares and bus cycles
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chkf(input string what, input frame_type exp, input frame_type got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk); #1; wr_s = 1; addr = a; wdata = d;
      @(posedge clk); #1; wr_s = 0;
   endtask
   // read, then compare the masked byte
   task automatic rdc(input string what, input logic [11:0] a, input logic [7:0] m,
         input logic [7:0] e);
      @(posedge clk); #1; rd_s = 1; addr = a;
      @(posedge clk); #1; rd_s = 0;
      chk8(what, e, rdata & m);
   endtask
   // the pin is held several cycles, so the two-flop sampler sees one rise
   task automatic pulse_ref();
      @(posedge clk); #1; sysref = 1;
      repeat (3) @(posedge clk);
      #1; sysref = 0;
      repeat (12) @(posedge clk);
   endtask
   // ==========================================================================
   // scenarios
   task automatic t_regs();
      rdc("unmapped", 12'h100, 8'hff, 8'h00);
      wr(12'h300, 8'h0c);
      rdc("link ctl", 12'h300, 8'h0c, 8'h0c);
      wr(12'h008, 8'h03);
      rdc("pair sel", 12'h008, 8'h03, 8'h03);
      for (int w = 0; w < 4; w++) begin
         wr(12'h034, 8'(w)); // window kept at 3 or less
         rdc("window", 12'h034, 8'h07, 8'(w));
      end
      wr(12'h03b, 8'hff);
      rdc("status ro", 12'h03b, 8'hff, 8'h00);
      wr(12'h300, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_frames();
      lane_en = 2'b11;
      repeat (3) @(posedge clk);
      #1; chkf("frame0", comma, frame[0]);
      chk8("link1 idle", 8'h00, {7'h0, frame[1].valid});
      wr(12'h300, 8'h08);
      @(posedge clk);
      #1; chk8("link1 run", 8'h01, {7'h0, frame[1].valid});
      wr(12'h453, 8'h80);
      repeat (4) @(posedge clk);
      #1; chk8("descrambled", 8'h01, {7'h0, frame[0].data !== comma.data});
      chkf("frame1 raw", comma, frame[1]);
      wr(12'h453, 8'h00);
      repeat (4) @(posedge clk);
      #1; chkf("frame0 raw", comma, frame[0]);
      $display("t_frames done");
   endtask
   task automatic t_oneshot();
      wr(12'h301, 8'h01);
      wr(12'h03a, 8'h81);
      wr(12'h03a, 8'hc1);
      pulse_ref();
      rdc("arm cleared", 12'h03a, 8'h40, 8'h00);
      rdc("locked", 12'h03b, 8'h89, 8'h09);
      rdc("cur err", 12'h03c, 8'hff, 8'h00);
      wr(12'h03a, 8'ha1);
      rdc("sticky cleared", 12'h03b, 8'h05, 8'h00);
      pulse_ref();
      rdc("later edge", 12'h03b, 8'h01, 8'h00);
      $display("t_oneshot done");
   endtask
   task automatic t_cont();
      wr(12'h021, 8'h04);
      wr(12'h03a, 8'h82);
      pulse_ref();
      rdc("cont trip", 12'h03b, 8'h01, 8'h01);
      chk8("irq set", 8'h01, {7'h0, irq});
      rdc("irq status", 12'h025, 8'h04, 8'h04);
      chk8("irq clear", 8'h00, {7'h0, irq});
      wr(12'h03a, 8'hc2);
      pulse_ref();
      rdc("cont arm", 12'h03a, 8'h4f, 8'h02);
      $display("t_cont done");
   endtask
   task automatic t_monitor();
      wr(12'h03a, 8'ha9);
      wr(12'h03a, 8'hc9);
      pulse_ref();
      rdc("mon align", 12'h03b, 8'h81, 8'h01);
      wr(12'h03a, 8'ha9);
      pulse_ref();
      rdc("mon no rotate", 12'h03b, 8'h05, 8'h01);
      wr(12'h03a, 8'he1);
      wr(12'h301, 8'h00);
      repeat (12) @(posedge clk);
      rdc("sub0 trip", 12'h03b, 8'h01, 8'h01);
      rdc("sub0 arm", 12'h03a, 8'h40, 8'h00);
      $display("t_monitor done");
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ==========================================================================
   // main sequence and watchdog
   initial begin
      repeat (16) @(posedge clk);
      #1; rst = 0;
      t_regs();
      t_frames();
      t_oneshot();
      t_cont();
      t_monitor();
      give_verdict();
   end
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
endmodule
`default_nettype wire
